// file: core/e1prb_pkg.sv
/*
  e1prb_pkg: constants, register map, field layout and state types of the
  e1 test pattern generator / checker.
  assumes one 50 MHz clock and an AXI4-Lite register bus.
*/
package e1prb_pkg;

  localparam int E1PRB_AW = 8;
  localparam int E1PRB_SLOT_W = 5;
  localparam int E1PRB_LFSR_W = 15;
  localparam int E1PRB_HIST_W = 64;
  localparam logic [6:0] E1PRB_LOSS_ERRS = 7'h06;
  localparam logic [4:0] E1PRB_SYNC_MATCHES = 5'h0f;
  localparam logic [14:0] E1PRB_GEN_SEED = 15'h7fff;
  localparam logic [15:0] E1PRB_CNT_MAX = 16'hffff;

  ////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] E1PRB_ADDR_PAT_CTRL = 8'h00;
  localparam logic [7:0] E1PRB_ADDR_TX_CTRL = 8'h04;
  localparam logic [7:0] E1PRB_ADDR_RX_CTRL = 8'h08;
  localparam logic [7:0] E1PRB_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] E1PRB_ADDR_ERR_CNT = 8'h10;
  localparam logic [7:0] E1PRB_ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] E1PRB_ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] E1PRB_ADDR_OUT_CFG = 8'h1c;

  // field positions
  localparam int E1PRB_TX_MODE_LSB = 2;
  localparam int E1PRB_RX_MODE_LSB = 0;
  localparam int E1PRB_EV_SYNC_ON = 0;
  localparam int E1PRB_EV_SYNC_OFF = 1;
  localparam int E1PRB_EV_BIT_ERR = 2;
  localparam int E1PRB_OUT_A = 0;
  localparam int E1PRB_OUT_B = 1;

  localparam logic [1:0] E1PRB_RESP_OKAY = 2'h0;
  localparam logic [1:0] E1PRB_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    E1PRB_OFF, E1PRB_ONE_SLOT, E1PRB_FRAMED, E1PRB_UNFRAMED
  } e1prb_mode_t;

  typedef enum logic {E1PRB_HUNT, E1PRB_LOCKED} e1prb_sync_t;

  typedef struct packed {
    e1prb_mode_t tx_mode;
    e1prb_mode_t rx_mode;
    logic [4:0] tx_slot;
    logic [4:0] rx_slot;
    logic [1:0] out_sel;
    logic [2:0] irq_mask;
    logic [2:0] irq_stat;
    logic [15:0] err_cnt;
    logic [14:0] gen;
    logic [14:0] chk;
    e1prb_sync_t sync;
    logic [4:0] good_cnt;
    logic [63:0] hist;
    logic tx_data;
    logic out_a;
    logic out_b;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } e1prb_state_t;

  localparam e1prb_state_t E1PRB_STATE_RST = '{
    tx_mode: E1PRB_OFF, rx_mode: E1PRB_OFF, sync: E1PRB_HUNT,
    gen: E1PRB_GEN_SEED, default: '0};

endpackage : e1prb_pkg

// file: core/e1prb_core.sv
/*
  e1prb_core: 2^15-1 test pattern generator and checker for one e1 port,
  with its AXI4-Lite register file and a level interrupt.
  assumes the framer supplies one-cycle bit enables and the current slot
  number on this same clock; no synchronisers are needed on those.
*/
`timescale 1ns/1ps
module e1prb_core
  import e1prb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic tx_bit_en,
  input wire logic [4:0] tx_slot_num,
  input wire logic tx_data_in,
  output logic tx_data_out,
  input wire logic rx_bit_en,
  input wire logic [4:0] rx_slot_num,
  input wire logic rx_data_in,
  input wire logic ebit_err_in,
  output logic user_output_a,
  output logic user_output_b,
  output logic irq
);

  e1prb_state_t s_reg;
  e1prb_state_t s_next;

  logic gen_fb;
  logic tx_hit;
  logic rx_step;
  logic pred;
  logic rx_err;
  logic locked;
  logic err_locked;
  logic [63:0] hist_sh;
  logic lose_now;
  logic wr_go;
  logic rd_go;
  logic rd_ok;
  logic [31:0] rd_word;
  logic [2:0] ev;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic slot_hit(input e1prb_mode_t m,
                                    input logic [4:0] slot,
                                    input logic [4:0] sel);
    case (m)
      E1PRB_ONE_SLOT: slot_hit = (slot == sel);
      E1PRB_FRAMED: slot_hit = (slot != '0);
      E1PRB_UNFRAMED: slot_hit = 1'b1;
      default: slot_hit = 1'b0;
    endcase
  endfunction : slot_hit

  function automatic logic [6:0] ones(input logic [63:0] v);
    logic [6:0] n;
    n = '0;
    for (int i = 0; i < E1PRB_HIST_W; i++) begin
      n = n + 7'(v[i]);
    end
    ones = n;
  endfunction : ones

  ////////////////////////////////////////////////////////////////////////
  // pattern datapath
  assign gen_fb = s_reg.gen[14] ^ s_reg.gen[13];
  assign tx_hit = tx_bit_en && slot_hit(s_reg.tx_mode, tx_slot_num, s_reg.tx_slot);
  assign rx_step = rx_bit_en && slot_hit(s_reg.rx_mode, rx_slot_num, s_reg.rx_slot);
  assign pred = s_reg.chk[14] ^ s_reg.chk[13];
  assign rx_err = rx_step && (rx_data_in != pred);
  assign locked = (s_reg.sync == E1PRB_LOCKED);
  assign err_locked = locked && rx_err;
  // sliding window of the last 64 checked bits, newest included
  assign hist_sh = {s_reg.hist[62:0], rx_err};
  assign lose_now = locked && rx_step && (ones(hist_sh) >= E1PRB_LOSS_ERRS);

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes: one write and one read in flight
  assign s_axi_awready = !s_reg.aw_full && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_full && !s_reg.bvalid;
  assign s_axi_arready = !s_reg.rvalid;
  assign wr_go = s_reg.aw_full && s_reg.w_full;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      E1PRB_ADDR_PAT_CTRL: begin
        rd_word[3:0] = {s_reg.tx_mode, s_reg.rx_mode};
      end
      E1PRB_ADDR_TX_CTRL: rd_word[4:0] = s_reg.tx_slot;
      E1PRB_ADDR_RX_CTRL: rd_word[4:0] = s_reg.rx_slot;
      E1PRB_ADDR_STATUS: rd_word[0] = locked;
      E1PRB_ADDR_ERR_CNT: rd_word[15:0] = s_reg.err_cnt;
      E1PRB_ADDR_IRQ_STAT: rd_word[2:0] = s_reg.irq_stat;
      E1PRB_ADDR_IRQ_MASK: rd_word[2:0] = s_reg.irq_mask;
      E1PRB_ADDR_OUT_CFG: rd_word[1:0] = s_reg.out_sel;
      default: rd_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    ev = '0;
    s_next.out_a = 1'b0;
    s_next.out_b = 1'b0;

    // transmit: pattern replaces line data in the selected slots
    if (tx_bit_en) begin
      s_next.tx_data = tx_data_in;
    end
    if (tx_hit) begin
      s_next.tx_data = gen_fb;
      s_next.gen = {s_reg.gen[13:0], gen_fb};
    end

    // receive checker
    if (rx_step) begin
      if (!locked) begin
        // hunting: load line bits, lock after a run of correct predictions
        s_next.chk = {s_reg.chk[13:0], rx_data_in};
        if (rx_err || s_reg.chk == '0) begin
          s_next.good_cnt = '0;
        end else if (s_reg.good_cnt == E1PRB_SYNC_MATCHES - 5'h1) begin
          s_next.sync = E1PRB_LOCKED;
          s_next.hist = '0;
          s_next.good_cnt = '0;
          ev[E1PRB_EV_SYNC_ON] = 1'b1;
        end else begin
          s_next.good_cnt = s_reg.good_cnt + 5'h1;
        end
      end else begin
        // locked: free-running reference so line errors do not propagate
        s_next.chk = {s_reg.chk[13:0], pred};
        s_next.hist = hist_sh;
        if (rx_err) begin
          ev[E1PRB_EV_BIT_ERR] = 1'b1;
          s_next.out_a = s_reg.out_sel[E1PRB_OUT_A];
          s_next.out_b = s_reg.out_sel[E1PRB_OUT_B];
        end
        if (lose_now) begin
          s_next.sync = E1PRB_HUNT;
          ev[E1PRB_EV_SYNC_OFF] = 1'b1;
        end
      end
    end
    if (s_reg.rx_mode == E1PRB_OFF) begin
      s_next.sync = E1PRB_HUNT;
      s_next.good_cnt = '0;
    end

    // write channel
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = E1PRB_RESP_OKAY;
      case (s_reg.aw_addr)
        E1PRB_ADDR_PAT_CTRL: begin
          if (s_reg.w_strb[0]) begin
            s_next.tx_mode = e1prb_mode_t'(s_reg.w_data[E1PRB_TX_MODE_LSB +: 2]);
            s_next.rx_mode = e1prb_mode_t'(s_reg.w_data[E1PRB_RX_MODE_LSB +: 2]);
          end
        end
        E1PRB_ADDR_TX_CTRL: begin
          if (s_reg.w_strb[0]) begin
            s_next.tx_slot = s_reg.w_data[4:0];
          end
        end
        E1PRB_ADDR_RX_CTRL: begin
          if (s_reg.w_strb[0]) begin
            s_next.rx_slot = s_reg.w_data[4:0];
          end
        end
        E1PRB_ADDR_ERR_CNT: s_next.err_cnt = '0;
        E1PRB_ADDR_IRQ_MASK: begin
          if (s_reg.w_strb[0]) begin
            s_next.irq_mask = s_reg.w_data[2:0];
          end
        end
        E1PRB_ADDR_OUT_CFG: begin
          if (s_reg.w_strb[0]) begin
            s_next.out_sel = s_reg.w_data[1:0];
          end
        end
        E1PRB_ADDR_STATUS, E1PRB_ADDR_IRQ_STAT: ;
        default: s_next.bresp = E1PRB_RESP_SLVERR;
      endcase
    end

    // error counter; a clearing write and a same-cycle error leave 1
    if (s_reg.rx_mode != E1PRB_OFF) begin
      if (err_locked && s_next.err_cnt != E1PRB_CNT_MAX) begin
        s_next.err_cnt = s_next.err_cnt + 16'h0001;
      end
    end else if (ebit_err_in && s_next.err_cnt != E1PRB_CNT_MAX) begin
      s_next.err_cnt = s_next.err_cnt + 16'h0001;
    end

    // read channel; reading the event register clears it, new events win
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word;
      s_next.rresp = rd_ok ? E1PRB_RESP_OKAY : E1PRB_RESP_SLVERR;
      if (s_axi_araddr == E1PRB_ADDR_IRQ_STAT) begin
        s_next.irq_stat = '0;
      end
    end
    s_next.irq_stat = s_next.irq_stat | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= E1PRB_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign tx_data_out = s_reg.tx_data;
  assign user_output_a = s_reg.out_a;
  assign user_output_b = s_reg.out_b;
  assign irq = |(s_reg.irq_stat & s_reg.irq_mask);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_GEN_BIT: assert property (tx_hit |=> tx_data_out == $past(gen_fb))
    else $error("generated bit is not the feedback bit");
  AST_CHK_REF: assert property (locked && rx_step |=> s_reg.chk[0] == $past(pred))
    else $error("locked checker did not advance on its own feedback");
  AST_TX_PASS: assert property (tx_bit_en && !tx_hit |=> tx_data_out == $past(tx_data_in))
    else $error("line data altered outside pattern slots");
  AST_RX_OFF: assert property (s_reg.rx_mode == E1PRB_OFF |=> !locked)
    else $error("checker locked while receive mode is off");
  AST_SLOT0_KEPT: assert property (
      tx_bit_en && s_reg.tx_mode == E1PRB_FRAMED && tx_slot_num == '0
      |=> tx_data_out == $past(tx_data_in))
    else $error("framed mode overwrote slot zero");
  AST_UNFRAMED: assert property (
      tx_bit_en && s_reg.tx_mode == E1PRB_UNFRAMED |=> tx_data_out == $past(gen_fb))
    else $error("unframed mode skipped a bit");
  AST_TX_ONE: assert property (
      tx_bit_en && s_reg.tx_mode == E1PRB_ONE_SLOT && tx_slot_num == s_reg.tx_slot
      |=> tx_data_out == $past(gen_fb))
    else $error("selected transmit slot carries no pattern");
  AST_RX_SKIP: assert property (
      rx_bit_en && s_reg.rx_mode == E1PRB_ONE_SLOT && rx_slot_num != s_reg.rx_slot
      |=> $stable(s_reg.chk))
    else $error("checker moved on an unselected slot");
  AST_SYNC_RD: assert property (
      rd_go && s_axi_araddr == E1PRB_ADDR_STATUS |=> s_axi_rdata[0] == $past(locked))
    else $error("status bit does not show lock");
  AST_HOLD: assert property (
      locked && !lose_now && s_reg.rx_mode != E1PRB_OFF |=> locked)
    else $error("lock dropped without six errors in 64 bits");
  AST_LOSE: assert property (lose_now |=> !locked ##1 s_reg.good_cnt <= 5'h1)
    else $error("lock kept after six errors in 64 bits");
  AST_CNT: assert property (
      s_reg.rx_mode != E1PRB_OFF && err_locked && !wr_go && s_reg.err_cnt != E1PRB_CNT_MAX
      |=> s_reg.err_cnt == $past(s_reg.err_cnt) + 16'h0001)
    else $error("pattern error not counted");
  AST_PULSE: assert property (user_output_a |-> $past(err_locked))
    else $error("error pulse without a locked bit error");
  AST_PULSE_ON: assert property (
      err_locked && s_reg.out_sel[E1PRB_OUT_A]
      |=> user_output_a ##1 (!user_output_a || $past(err_locked)))
    else $error("locked bit error gave no pulse");
  AST_PULSE_B: assert property (user_output_b |-> $past(err_locked))
    else $error("second error pulse without a locked bit error");

endmodule : e1prb_core

// file: tb/e1prb_line_model.sv
/*
  e1prb_line_model: framer timing plus a looped-back line for one port.
  assumes the bench stops it (run low) around pattern mode writes.
*/
`timescale 1ns/1ps
module e1prb_line_model (
  input wire logic aclk,
  input wire logic run,
  input wire logic err_req,
  input wire logic tx_data_out,
  output logic tx_bit_en,
  output logic [4:0] tx_slot_num,
  output logic tx_data_in,
  output logic rx_bit_en,
  output logic [4:0] rx_slot_num,
  output logic rx_data_in
);
  logic [1:0] ph_reg = 2'h0;
  logic [7:0] bit_reg = 8'h00;
  logic fire_reg = 1'h0;
  logic [4:0] slot_reg = 5'h00;
  logic pend_reg = 1'h0;
  logic pat;
  ////////////////////////////////////////////////////////////////////////
  // one bit every 4 clocks, 8 bits per slot, 32 slots per frame
  assign tx_bit_en = run && (ph_reg == 2'h0);
  assign tx_slot_num = bit_reg[7:3];
  assign pat = bit_reg[0] ^ bit_reg[5];
  // off the bit strobe the lines show the inverse, so stale data cannot pass
  assign tx_data_in = tx_bit_en ? pat : !pat;
  assign rx_bit_en = fire_reg;
  assign rx_slot_num = slot_reg;
  assign rx_data_in = fire_reg ? (tx_data_out ^ pend_reg) : !tx_data_out;
  always @(posedge aclk) begin
    ph_reg <= ph_reg + 2'h1;
    fire_reg <= tx_bit_en;
    slot_reg <= tx_slot_num;
    if (tx_bit_en) begin
      bit_reg <= bit_reg + 8'h01;
    end
    // a requested error corrupts the next received bit only
    if (err_req) begin
      pend_reg <= 1'h1;
    end else if (fire_reg) begin
      pend_reg <= 1'h0;
    end
  end
endmodule : e1prb_line_model

// file: tb/tb_e1prb_core.sv
/*
  tb_e1prb_core: register-level tests of the pattern generator / checker.
  assumes the line model loops transmit back to receive on one clock.
*/
`timescale 1ns/1ps
module tb_e1prb_core
  import e1prb_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic tx_bit_en, tx_data_in, tx_data_out, rx_bit_en, rx_data_in;
  logic [4:0] tx_slot_num, rx_slot_num;
  logic ebit_err_in = 1'h0, run = 1'h0, err_req = 1'h0;
  logic user_output_a, user_output_b, irq;
  int fails = 0, check_count = 0, a_cnt = 0, b_cnt = 0, a0;
  logic [1:0] tx_m = 2'h0;
  logic [4:0] tx_s = 5'h00;
  logic [14:0] g = 15'h7fff;
  logic tx_pend = 1'h0, tx_exp, sel;
  initial begin
    forever #10 aclk = !aclk;
  end
  e1prb_core e1prb_core_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .tx_bit_en(tx_bit_en), .tx_slot_num(tx_slot_num), .tx_data_in(tx_data_in),
    .tx_data_out(tx_data_out), .rx_bit_en(rx_bit_en), .rx_slot_num(rx_slot_num),
    .rx_data_in(rx_data_in), .ebit_err_in(ebit_err_in), .user_output_a(user_output_a),
    .user_output_b(user_output_b), .irq(irq));
  e1prb_line_model e1prb_line_model_inst (.aclk(aclk), .run(run), .err_req(err_req),
    .tx_data_out(tx_data_out), .tx_bit_en(tx_bit_en), .tx_slot_num(tx_slot_num),
    .tx_data_in(tx_data_in), .rx_bit_en(rx_bit_en), .rx_slot_num(rx_slot_num),
    .rx_data_in(rx_data_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // no wait limit here: only the watchdog ends a hung transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    cmp({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'h1, er});
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    cmp({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'h1, er});
    cmp(s_axi_rdata, exp);
    @(posedge aclk);
  endtask : rd
  // line stopped while modes change, so the reference generator stays aligned
  task automatic mode(input logic [1:0] t, input logic [1:0] r);
    run <= 1'h0;
    repeat (4) @(posedge aclk);
    wr(E1PRB_ADDR_PAT_CTRL, {28'h0, t, r}, E1PRB_RESP_OKAY);
    tx_m = t;
    run <= 1'h1;
  endtask : mode
  task automatic line_err(input int n);
    repeat (n) begin
      err_req <= 1'h1;
      @(posedge aclk);
      err_req <= 1'h0;
      repeat (15) @(posedge aclk);
    end
  endtask : line_err
  task automatic ebit(input int n);
    repeat (n) begin
      ebit_err_in <= 1'h1;
      @(posedge aclk);
      ebit_err_in <= 1'h0;
      @(posedge aclk);
    end
  endtask : ebit
  task automatic final_report;
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////
  // transmit reference: x^15 + x^14 + 1 from the all-ones seed
  always @(posedge aclk) begin
    if (tx_pend) cmp({31'h0, tx_data_out}, {31'h0, tx_exp});
    tx_pend = 1'h0;
    if (tx_bit_en === 1'h1) begin
      sel = (tx_m == 2'h3) || (tx_m == 2'h2 && tx_slot_num != 5'h00) ||
            (tx_m == 2'h1 && tx_slot_num == tx_s);
      tx_exp = sel ? (g[14] ^ g[13]) : tx_data_in;
      if (sel) g = {g[13:0], tx_exp};
      tx_pend = 1'h1;
    end
    if (user_output_a === 1'h1) a_cnt++;
    if (user_output_b === 1'h1) b_cnt++;
  end
  initial begin
    #1_000_000;
    fails++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0000_0000, E1PRB_RESP_OKAY);
    rd(8'h20, 32'h0000_0000, E1PRB_RESP_SLVERR);
    wr(8'h24, 32'hffff_ffff, E1PRB_RESP_SLVERR);
    wr(E1PRB_ADDR_TX_CTRL, 32'h0000_00f1, E1PRB_RESP_OKAY);
    wr(E1PRB_ADDR_RX_CTRL, 32'h0000_00f1, E1PRB_RESP_OKAY);
    rd(E1PRB_ADDR_TX_CTRL, 32'h0000_0011, E1PRB_RESP_OKAY);
    rd(E1PRB_ADDR_RX_CTRL, 32'h0000_0011, E1PRB_RESP_OKAY);
    // a write without its low byte lane must leave the slot selection alone
    s_axi_wstrb <= 4'he;
    wr(E1PRB_ADDR_RX_CTRL, 32'h0000_0003, E1PRB_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(E1PRB_ADDR_RX_CTRL, 32'h0000_0011, E1PRB_RESP_OKAY);
    tx_s = 5'h11;
    wr(E1PRB_ADDR_IRQ_MASK, 32'h0000_0007, E1PRB_RESP_OKAY);
    wr(E1PRB_ADDR_OUT_CFG, 32'h0000_0001, E1PRB_RESP_OKAY);
    cmp({31'h0, irq}, 32'h0000_0000);
    for (int m = 3; m > 0; m--) begin
      mode(m[1:0], m[1:0]);
      repeat (3072) @(posedge aclk);
      rd(E1PRB_ADDR_STATUS, 32'h0000_0001, E1PRB_RESP_OKAY);
    end
    cmp({31'h0, irq}, 32'h0000_0001);
    rd(E1PRB_ADDR_IRQ_STAT, 32'h0000_0001, E1PRB_RESP_OKAY);
    cmp({31'h0, irq}, 32'h0000_0000);
    mode(2'h3, 2'h3);
    wr(E1PRB_ADDR_ERR_CNT, 32'h0000_0000, E1PRB_RESP_OKAY);
    line_err(1);
    repeat (400) @(posedge aclk);
    line_err(5);
    repeat (400) @(posedge aclk);
    rd(E1PRB_ADDR_STATUS, 32'h0000_0001, E1PRB_RESP_OKAY);
    rd(E1PRB_ADDR_ERR_CNT, 32'h0000_0006, E1PRB_RESP_OKAY);
    cmp(a_cnt, 6);
    rd(E1PRB_ADDR_IRQ_STAT, 32'h0000_0004, E1PRB_RESP_OKAY);
    line_err(6);
    run <= 1'h0;
    rd(E1PRB_ADDR_STATUS, 32'h0000_0000, E1PRB_RESP_OKAY);
    wr(E1PRB_ADDR_IRQ_MASK, 32'h0000_0000, E1PRB_RESP_OKAY);
    cmp({31'h0, irq}, 32'h0000_0000);
    wr(E1PRB_ADDR_IRQ_MASK, 32'h0000_0007, E1PRB_RESP_OKAY);
    cmp({31'h0, irq}, 32'h0000_0001);
    rd(E1PRB_ADDR_IRQ_STAT, 32'h0000_0006, E1PRB_RESP_OKAY);
    a0 = a_cnt;
    wr(E1PRB_ADDR_OUT_CFG, 32'h0000_0002, E1PRB_RESP_OKAY);
    run <= 1'h1;
    repeat (400) @(posedge aclk);
    line_err(1);
    repeat (40) @(posedge aclk);
    cmp(b_cnt, 1);
    cmp(a_cnt, a0);
    // with checking off, the counter goes back to counting e-bit errors
    mode(2'h0, 2'h0);
    rd(E1PRB_ADDR_STATUS, 32'h0000_0000, E1PRB_RESP_OKAY);
    wr(E1PRB_ADDR_ERR_CNT, 32'h0000_0000, E1PRB_RESP_OKAY);
    ebit(3);
    rd(E1PRB_ADDR_ERR_CNT, 32'h0000_0003, E1PRB_RESP_OKAY);
    mode(2'h0, 2'h3);
    ebit(2);
    rd(E1PRB_ADDR_ERR_CNT, 32'h0000_0003, E1PRB_RESP_OKAY);
    // single-slot lock from a cold hunt: 8 pattern bits per frame, 6 frames
    mode(2'h1, 2'h1);
    repeat (6144) @(posedge aclk);
    rd(E1PRB_ADDR_STATUS, 32'h0000_0001, E1PRB_RESP_OKAY);
    final_report();
  end
endmodule : tb_e1prb_core
